//--- decp_map.vh
// Purpose: constants for the two-edge capture channel pair
// Assumes: 16-bit free-running counter value, 2-bit edge selections
// Notes: definitions only
`ifndef DECP_MAP_VH
`define DECP_MAP_VH
`define DECP_CNT_W 16
`define DECP_EDGE_NONE 2'h0
`define DECP_EDGE_RISE 2'h1
`define DECP_EDGE_FALL 2'h2
`define DECP_EDGE_BOTH 2'h3
`define DECP_VAL_RST 16'h0000
`define DECP_FLT_W 4
`define DECP_FLT_CNT_W 5
`define DECP_CH_FILTER0 2'h0
`define DECP_CH_FILTER2 2'h2
`endif

//--- decp_sync.v
// Purpose: two-stage synchroniser for the measured input
// Assumes: input is asynchronous to clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module decp_sync (
  input wire clk,
  input wire sys_rst,
  input wire async_in,
  output reg sync_out
);
  reg meta_reg; // first stage, metastability catcher

  // two flops before any logic reads the pin
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // decp_sync
`default_nettype wire

//--- decp_filter.v
// Purpose: glitch filter for the synchronised even input
// Assumes: filt_val zero means pass-through
// Notes: a new level must hold filt_val+1 clocks before it is accepted
`timescale 1ns/1ps
`default_nettype none
`include "decp_map.vh"
module decp_filter (
  input wire clk,
  input wire sys_rst,
  input wire din,
  input wire filt_on,
  input wire [`DECP_FLT_W-1:0] filt_val,
  output reg dout
);
  reg [`DECP_FLT_CNT_W-1:0] cnt_reg; // stability counter
  wire bypass; // filter inactive

  assign bypass = ~filt_on | (filt_val == {`DECP_FLT_W{1'b0}});

  // count while the input differs from the accepted level
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_reg <= {`DECP_FLT_CNT_W{1'b0}};
      dout <= 1'b0;
    end
    else if (bypass)
    begin
      cnt_reg <= {`DECP_FLT_CNT_W{1'b0}};
      dout <= din;
    end
    else if (din == dout)
    begin
      // glitch ended before validation: restart
      cnt_reg <= {`DECP_FLT_CNT_W{1'b0}};
    end
    else if (cnt_reg >= {1'b0, filt_val})
    begin
      cnt_reg <= {`DECP_FLT_CNT_W{1'b0}};
      dout <= din;
    end
    else
    begin
      cnt_reg <= cnt_reg + {{(`DECP_FLT_CNT_W-1){1'b0}}, 1'b1};
    end
  end
endmodule // decp_filter
`default_nettype wire

//--- decp_pair.v
// Purpose: two-edge capture logic for one even/odd channel pair
// Assumes: counter is supplied free running on clk; software pulses are one cycle
// Notes: value outputs are the software-visible value registers
`timescale 1ns/1ps
`default_nettype none
`include "decp_map.vh"
// Functional notes
// - mode needs enhanced enable and pair enable
// - filter only for even channel 0 or 2
// - mode bit 0: one pair per arming
// - mode bit 1: capture pairs continuously while armed
// - even select first edge, odd second
// - odd channel input ignored entirely
// - first edge sets even flag, maybe interrupt
// - second edge sets odd flag only after even
// - counter latched into even then odd values
// - values coherent; read even before odd
// - capture only while arm bit set
// - one-shot clears arm at second edge
// - one-shot takes single edge pair only
// - continuous: odd flag per pair, values overwritten
// - continuous: odd flag clear alone, newest pair
// - rise then fall positive width, reverse negative
// - same polarity selects period measurement
// - even value read moves odd buffer out
module decp_pair #(
  parameter [1:0] EVEN_CH = 2'h0
) (
  input wire clk,
  input wire sys_rst,
  input wire even_in,
  input wire odd_in,
  input wire [`DECP_CNT_W-1:0] counter_value,
  input wire enhanced_features_enable,
  input wire pair_two_edge_capture_enable,
  input wire channel_mode_select_a,
  input wire [1:0] even_edge_select,
  input wire [1:0] odd_edge_select,
  input wire even_interrupt_enable,
  input wire odd_interrupt_enable,
  input wire filter_enable,
  input wire [`DECP_FLT_W-1:0] filter_value,
  input wire capture_arm_set,
  input wire capture_arm_clear,
  input wire even_flag_clear,
  input wire odd_flag_clear,
  input wire even_value_read,
  output reg capture_arm_reg,
  output reg even_event_flag_reg,
  output reg odd_event_flag_reg,
  output wire even_irq,
  output wire odd_irq,
  output reg [`DECP_CNT_W-1:0] even_value_reg,
  output reg [`DECP_CNT_W-1:0] odd_value_reg,
  output wire dual_mode_active,
  output wire measure_period,
  output wire measure_positive_width,
  output wire measure_negative_width
);
  wire in_sync; // synchronised even input
  wire in_filt; // filtered even input
  wire filt_allowed; // filter permitted on this pair
  reg in_prev_reg; // previous sample for edge detection
  wire rise; // rising edge this cycle
  wire fall; // falling edge this cycle
  wire even_edge_hit; // first-edge selection matched
  wire odd_edge_hit; // second-edge selection matched
  wire cap_first; // capture the first edge now
  wire cap_second; // capture the second edge now
  reg [`DECP_CNT_W-1:0] even_buf_reg; // even capture buffer
  reg [`DECP_CNT_W-1:0] odd_buf_reg; // odd capture buffer
  reg odd_buf_new_reg; // odd buffer holds an unread pair
  reg first_seen_reg; // first edge of current pair taken

  // the odd pin is never looked at in this mode
  wire unused_odd = odd_in;

  assign dual_mode_active = enhanced_features_enable & pair_two_edge_capture_enable;

  // filtering only reaches the even channels 0 and 2
  assign filt_allowed = filter_enable &
    ((EVEN_CH == `DECP_CH_FILTER0) | (EVEN_CH == `DECP_CH_FILTER2));

  decp_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(even_in),
    .sync_out(in_sync)
  );

  decp_filter u_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(in_sync),
    .filt_on(filt_allowed),
    .filt_val(filter_value),
    .dout(in_filt)
  );

  // edge detector sampled once per clock
  always @(posedge clk)
  begin
    if (sys_rst)
      in_prev_reg <= 1'b0;
    else
      in_prev_reg <= in_filt;
  end

  assign rise = in_filt & ~in_prev_reg;
  assign fall = ~in_filt & in_prev_reg;

  // both channel selections look at the even input only
  assign even_edge_hit = (even_edge_select[0] & rise) | (even_edge_select[1] & fall);
  assign odd_edge_hit = (odd_edge_select[0] & rise) | (odd_edge_select[1] & fall);

  // classification of the measurement set up by software
  assign measure_period = (even_edge_select == odd_edge_select) &
    (even_edge_select != `DECP_EDGE_NONE);
  assign measure_positive_width = (even_edge_select == `DECP_EDGE_RISE) &
    (odd_edge_select == `DECP_EDGE_FALL);
  assign measure_negative_width = (even_edge_select == `DECP_EDGE_FALL) &
    (odd_edge_select == `DECP_EDGE_RISE);

  // second edge needs the first one and the even flag; first edge otherwise
  assign cap_second = dual_mode_active & capture_arm_reg & first_seen_reg &
    even_event_flag_reg & odd_edge_hit;
  assign cap_first = dual_mode_active & capture_arm_reg & ~first_seen_reg &
    even_edge_hit;

  // arm bit: one-shot drops it after the second edge
  always @(posedge clk)
  begin
    if (sys_rst)
      capture_arm_reg <= 1'b0;
    else if (cap_second & ~channel_mode_select_a)
      capture_arm_reg <= 1'b0;
    else if (capture_arm_set)
      capture_arm_reg <= 1'b1;
    else if (capture_arm_clear)
      capture_arm_reg <= 1'b0;
  end

  // pair sequencing: first, then second, then again if continuous
  always @(posedge clk)
  begin
    if (sys_rst)
      first_seen_reg <= 1'b0;
    else if (~dual_mode_active | ~capture_arm_reg)
      first_seen_reg <= 1'b0;
    else if (cap_second)
      first_seen_reg <= 1'b0; // next pair may begin
    else if (cap_first)
      first_seen_reg <= 1'b1;
  end

  // event flags: hardware set wins over a clear in the same cycle
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      even_event_flag_reg <= 1'b0;
      odd_event_flag_reg <= 1'b0;
    end
    else
    begin
      if (cap_first)
        even_event_flag_reg <= 1'b1;
      else if (even_flag_clear)
        even_event_flag_reg <= 1'b0;
      if (cap_second)
        odd_event_flag_reg <= 1'b1;
      else if (odd_flag_clear)
        odd_event_flag_reg <= 1'b0;
    end
  end

  assign even_irq = even_event_flag_reg & even_interrupt_enable;
  assign odd_irq = odd_event_flag_reg & odd_interrupt_enable;

  // capture buffers and coherent value registers
  // even buffer moves out at the second edge so the pair stays matched;
  // odd buffer moves out on the even read, so read even first
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      even_buf_reg <= `DECP_VAL_RST;
      odd_buf_reg <= `DECP_VAL_RST;
      odd_buf_new_reg <= 1'b0;
      even_value_reg <= `DECP_VAL_RST;
      odd_value_reg <= `DECP_VAL_RST;
    end
    else
    begin
      if (cap_first)
        even_buf_reg <= counter_value;
      if (cap_second)
      begin
        even_value_reg <= even_buf_reg;
        odd_buf_reg <= counter_value;
        odd_buf_new_reg <= 1'b1;
      end
      else if (even_value_read & odd_buf_new_reg)
      begin
        odd_value_reg <= odd_buf_reg;
        odd_buf_new_reg <= 1'b0;
      end
    end
  end
endmodule // decp_pair
`default_nettype wire

//--- decp_pin_model.sv
// Purpose: drives the measured even-channel pin
// Assumes: one go pulse gives one clean high pulse
// Notes: the pin idles low outside pulses
`timescale 1ns/1ps
`default_nettype none
module decp_pin_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] hi_len,
  output logic pin
);
  logic [7:0] left_reg; // high cycles still to go
  initial pin = 1'b0;
  initial left_reg = 8'h00;
  // single-edge pulses only, so each edge is unambiguous
  always @(posedge clk)
  begin
    if (go)
    begin
      pin <= 1'b1;
      left_reg <= hi_len - 8'h01;
    end
    else if (left_reg != 8'h00)
      left_reg <= left_reg - 8'h01;
    else
      pin <= 1'b0;
  end
endmodule // decp_pin_model
`default_nettype wire

//--- decp_pair_asserts.sv
// Purpose: port-level checks for the capture pair
// Assumes: one clock, synchronous reset
// Notes: bound onto decp_pair
`timescale 1ns/1ps
`default_nettype none
module decp_pair_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enhanced_features_enable,
  input wire logic pair_two_edge_capture_enable,
  input wire logic channel_mode_select_a,
  input wire logic capture_arm_set,
  input wire logic capture_arm_clear,
  input wire logic even_interrupt_enable,
  input wire logic odd_interrupt_enable,
  input wire logic even_value_read,
  input wire logic capture_arm_reg,
  input wire logic even_event_flag_reg,
  input wire logic odd_event_flag_reg,
  input wire logic even_irq,
  input wire logic odd_irq,
  input wire logic [15:0] even_value_reg,
  input wire logic [15:0] odd_value_reg,
  input wire logic dual_mode_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // a pair completes when the odd flag rises
  sequence s_pair_done;
    $rose(odd_event_flag_reg);
  endsequence
  a_mode_gate: assert property (dual_mode_active ==
    (enhanced_features_enable && pair_two_edge_capture_enable)) else $error("mode gate");
  a_even_irq: assert property (even_irq ==
    (even_event_flag_reg && even_interrupt_enable)) else $error("even irq");
  a_odd_irq: assert property (odd_irq ==
    (odd_event_flag_reg && odd_interrupt_enable)) else $error("odd irq");
  a_odd_after_even: assert property (s_pair_done |-> $past(even_event_flag_reg))
    else $error("odd flag without even");
  a_arm_gates_capture: assert property ($rose(even_event_flag_reg) |->
    $past(capture_arm_reg && dual_mode_active)) else $error("capture unarmed");
  a_oneshot_disarm: assert property (s_pair_done |->
    $past(channel_mode_select_a || capture_arm_set) || !capture_arm_reg) else $error("arm kept");
  a_cont_keeps_arm: assert property (s_pair_done |->
    !$past(channel_mode_select_a && !capture_arm_clear) || capture_arm_reg) else $error("arm lost");
  a_odd_val_on_read: assert property (!$past(even_value_read) |-> $stable(odd_value_reg))
    else $error("odd value moved");
  a_even_val_at_pair: assert property ($changed(even_value_reg) |-> odd_event_flag_reg)
    else $error("even value early");
endmodule // decp_pair_asserts
bind decp_pair decp_pair_asserts i_chk (.*);
`default_nettype wire

//--- decp_tb.sv
// Purpose: self-checking bench for decp_pair
// Assumes: filter bypassed; free counter made here
// Notes: widths are judged as odd minus even value
`timescale 1ns/1ps
`default_nettype none
`include "decp_map.vh"
module testbench;
  logic clk, sys_rst, oin, ms, en, ien, fe, ac;
  logic [4:0] cmd; // go, arm set, even clr, odd clr, read
  logic [1:0] es, os;
  logic [7:0] hi;
  logic [15:0] cnt, ev, ov;
  logic pin, arm, ef, of, ei, oi, dm, mp, mpw, mnw;
  int n_errors, tests_run, cyc;
  decp_pin_model i_pin (.clk(clk), .go(cmd[4]), .hi_len(hi), .pin(pin));
  decp_pair i_dut (.clk(clk), .sys_rst(sys_rst), .even_in(pin), .odd_in(oin),
    .counter_value(cnt), .enhanced_features_enable(fe),
    .pair_two_edge_capture_enable(en), .channel_mode_select_a(ms),
    .even_edge_select(es), .odd_edge_select(os), .even_interrupt_enable(ien),
    .odd_interrupt_enable(ien), .filter_enable(1'b0), .filter_value(4'h0),
    .capture_arm_set(cmd[3]), .capture_arm_clear(ac), .even_flag_clear(cmd[2]),
    .odd_flag_clear(cmd[1]), .even_value_read(cmd[0]), .capture_arm_reg(arm),
    .even_event_flag_reg(ef), .odd_event_flag_reg(of), .even_irq(ei), .odd_irq(oi),
    .even_value_reg(ev), .odd_value_reg(ov), .dual_mode_active(dm),
    .measure_period(mp), .measure_positive_width(mpw), .measure_negative_width(mnw));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // free counter; odd pin toggles to prove it is ignored
  always @(posedge clk)
  begin
    if (sys_rst)
      cnt <= 16'h0000;
    else
      cnt <= cnt + 16'h0001;
    oin <= cnt[2];
    cyc <= cyc + 1;
    if (cyc > 5000)
    begin
      n_errors++;
      final_report;
    end
  end
  task automatic final_report;
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one-cycle software pulse; returns settled after the edge
  task automatic strobe(input logic [4:0] c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= 5'h00;
    #1;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_pair;
    int i;
    for (i = 0; i < 300 && of !== 1'b1; i++)
      idle(1);
    check(16'(of), 16'h0001);
    check(16'({ei, oi}), 16'(ien ? 2'h3 : 2'h0));
  endtask
  task automatic measure(input logic m, input logic [1:0] e, input logic [1:0] o,
      input logic [7:0] h, input int gap, input logic [15:0] exp, input logic [2:0] k);
    @(posedge clk);
    ms <= m;
    es <= e;
    os <= o;
    hi <= h;
    strobe(5'h06);
    strobe(5'h08);
    strobe(5'h10);
    if (gap > 0)
    begin
      idle(gap - 2);
      strobe(5'h10);
    end
    wait_pair;
    strobe(5'h01);
    check(ov - ev, exp);
    check(16'(arm), 16'(m));
    check(16'({mp, mpw, mnw}), 16'(k));
  endtask
  task automatic t_oneshot;
    measure(1'b0, `DECP_EDGE_RISE, `DECP_EDGE_FALL, 8'd7, 0, 16'd7, 3'b010);
    strobe(5'h10);
    idle(20);
    check(ov - ev, 16'd7);
  endtask
  task automatic t_cont_period;
    measure(1'b1, `DECP_EDGE_RISE, `DECP_EDGE_RISE, 8'd4, 12, 16'd12, 3'b100);
    strobe(5'h02);
    strobe(5'h10);
    idle(7);
    strobe(5'h10);
    wait_pair;
    strobe(5'h01);
    check(ov - ev, 16'd9);
    // software disarm keeps the last pair readable
    @(posedge clk);
    ac <= 1'b1;
    @(posedge clk);
    ac <= 1'b0;
    #1;
    check(16'(arm), 16'h0000);
    strobe(5'h10);
    idle(20);
    strobe(5'h01);
    check(ov - ev, 16'd9);
  endtask
  task automatic t_off;
    @(posedge clk);
    ien <= 1'b0;
    fe <= 1'b0;
    idle(1);
    check(16'({ei, oi}), 16'h0000);
    strobe(5'h06);
    strobe(5'h08);
    strobe(5'h10);
    idle(20);
    check(16'({dm, ef}), 16'h0000);
    @(posedge clk);
    fe <= 1'b1;
    en <= 1'b0;
    strobe(5'h06);
    strobe(5'h08);
    strobe(5'h10);
    idle(20);
    check(16'({dm, ef}), 16'h0000);
  endtask
  initial
  begin
    {ms, es, os, hi, cmd, ac} = '0;
    {sys_rst, ien, en, fe} = 4'b1111;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    idle(3);
    t_oneshot;
    t_cont_period;
    measure(1'b0, `DECP_EDGE_FALL, `DECP_EDGE_RISE, 8'd5, 15, 16'd10, 3'b001);
    t_off;
    final_report;
  end
endmodule // testbench
`default_nettype wire
